// ===== core/pso_top.sv
`timescale 1ns/100ps
`default_nettype none
module pso_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_enable_pin,
  input  wire logic        ssi_clk_in,
  output logic             ssi_data_out,
  output logic             error_out_n,
  input  wire logic [31:0] position_in,
  input  wire logic        pos_error,
  input  wire logic        pos_warning,
  input  wire logic [31:0] nvm_interface_cfg,
  input  wire logic        nvm_config_valid,
  output logic             spi_sclk,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  output logic             spi_cs_n,
  output logic             irq
);
  import pso_pkg::*;

  logic [31:0] interface_config_reg;
  logic [31:0] main_config_reg;
  logic [31:0] position_value_reg;
  logic [31:0] spi_rx_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_mask_reg;
  logic [7:0]  init_cnt_reg;
  logic        init_done_reg;
  logic        sen_low_seen_reg;
  logic        nvm_ok_reg;
  logic        ssi_en_reg;
  logic        sen_s1_reg, sen_s2_reg;
  logic        sck_s1_reg, sck_s2_reg;
  logic        miso_s1_reg, miso_s2_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [31:0] spi_rx_word;
  logic        spi_rx_done;
  logic        spi_busy;
  logic        frame_done;

  // Address decode shared by the read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    return a == ADDR_IFACE_CFG || a == ADDR_MAIN_CFG || a == ADDR_POSITION ||
           a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK || a == ADDR_SPI_RX ||
           a == ADDR_STATE;
  endfunction

  function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pins from other clock domains pass two flops before use
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Reset at the requesting level; a high value would clear sen_low_seen_reg and rule out SSI mode
      sen_s1_reg  <= 1'b0;
      sen_s2_reg  <= 1'b0;
      sck_s1_reg  <= 1'b1;
      sck_s2_reg  <= 1'b1;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      sen_s1_reg  <= serial_enable_pin;
      sen_s2_reg  <= sen_s1_reg;
      sck_s1_reg  <= ssi_clk_in;
      sck_s2_reg  <= sck_s1_reg;
      miso_s1_reg <= spi_miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // Write channel decode
  wire        do_write  = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire        wr_cfg    = do_write & (awaddr_reg == ADDR_IFACE_CFG);
  wire        wr_main   = do_write & (awaddr_reg == ADDR_MAIN_CFG);
  wire        wr_status = do_write & (awaddr_reg == ADDR_IRQ_STATUS);
  wire        wr_mask   = do_write & (awaddr_reg == ADDR_IRQ_MASK);
  wire [31:0] wr_merged = apply_strobe(WORD_ZERO, wdata_reg, wstrb_reg);
  wire [31:0] cfg_at_init = nvm_config_valid ? nvm_interface_cfg : interface_config_reg;
  wire        init_last = ~init_done_reg & (init_cnt_reg == INIT_LAST);
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Initialization: count, watch the enable pin, take memory settings at the end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      init_cnt_reg     <= 8'h00;
      init_done_reg    <= 1'b0;
      sen_low_seen_reg <= 1'b1;
      nvm_ok_reg       <= 1'b0;
      ssi_en_reg       <= 1'b0;
      error_out_n      <= 1'b0;
    end else if (!init_done_reg) begin
      init_cnt_reg <= init_cnt_reg + 8'h01;
      if (sen_s2_reg) begin
        sen_low_seen_reg <= 1'b0;
      end
      if (init_last) begin
        init_done_reg <= 1'b1;
        error_out_n   <= 1'b1;
        nvm_ok_reg    <= nvm_config_valid;
        // Decided once; later writes of the select bit do not switch modes
        ssi_en_reg <= sen_low_seen_reg & ~sen_s2_reg & cfg_at_init[SEL_BIT] &
                      nvm_config_valid;
      end
    end
  end

  // Configuration registers; memory copy wins at the end of init
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      interface_config_reg <= IFACE_CFG_RST;
      main_config_reg      <= MAIN_CFG_RST;
      irq_mask_reg         <= IRQ_RST;
    end else begin
      if (init_last) begin
        interface_config_reg <= cfg_at_init;
      end else if (wr_cfg) begin
        interface_config_reg <= apply_strobe(interface_config_reg, wdata_reg, wstrb_reg);
      end
      if (wr_main) begin
        main_config_reg <= apply_strobe(main_config_reg, wdata_reg, wstrb_reg);
      end
      if (wr_mask) begin
        irq_mask_reg <= wr_merged[1:0];
      end
    end
  end

  // Sticky events; a new event beats a write-one-to-clear in the same cycle
  wire [1:0] irq_set = {spi_rx_done, frame_done};
  wire [1:0] irq_clr = wr_status ? wr_merged[1:0] : IRQ_RST;
  assign irq = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_status_reg     <= IRQ_RST;
      position_value_reg <= WORD_ZERO;
      spi_rx_reg         <= WORD_ZERO;
    end else begin
      irq_status_reg     <= (irq_status_reg & ~irq_clr) | irq_set;
      position_value_reg <= position_in;
      if (spi_rx_done) begin
        spi_rx_reg <= spi_rx_word;
      end
    end
  end

  // AXI write handshake: address and data in either order, then one response
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= WORD_ZERO;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; state word shows what the block decided at init
  wire [31:0] state_word = {28'h0000000, spi_busy, nvm_ok_reg, init_done_reg, ssi_en_reg};
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_IFACE_CFG)  ? interface_config_reg :
    (s_axi_araddr == ADDR_MAIN_CFG)   ? main_config_reg :
    (s_axi_araddr == ADDR_POSITION)   ? position_value_reg :
    (s_axi_araddr == ADDR_IRQ_STATUS) ? {30'h00000000, irq_status_reg} :
    (s_axi_araddr == ADDR_IRQ_MASK)   ? {30'h00000000, irq_mask_reg} :
    (s_axi_araddr == ADDR_SPI_RX)     ? spi_rx_reg :
    (s_axi_araddr == ADDR_STATE)      ? state_word : WORD_ZERO;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= WORD_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Frame word: SPI data replaces the position while the SPI master runs
  wire        spi_en      = main_config_reg[MODE_SPI_BIT];
  wire        short_frame = interface_config_reg[SHORT_BIT];
  wire [31:0] src_word    = spi_en ? spi_rx_reg
                                   : {position_value_reg[29:0], pos_error, pos_warning};
  wire [31:0] src_short   = spi_en ? {spi_rx_reg[19:0], SHORT_PAD}
                                   : {position_value_reg[17:0], pos_error, pos_warning,
                                      SHORT_PAD};
  wire [31:0] frame_word  = short_frame ? src_short : src_word;

  pso_ssi_tx u_ssi (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .enable        (ssi_en_reg),
    .ring_mode     (interface_config_reg[RING_BIT]),
    .short_frame   (short_frame),
    .timeout_field (interface_config_reg[TMO_LSB +: TMO_W]),
    .frame_word    (frame_word),
    .sck_level     (sck_s2_reg),
    .data_out      (ssi_data_out),
    .frame_done    (frame_done)
  );

  pso_spi_master u_spi (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .enable     (spi_en),
    .tx_word    (position_value_reg),
    .miso_level (miso_s2_reg),
    .spi_sclk   (spi_sclk),
    .spi_mosi   (spi_mosi),
    .spi_cs_n   (spi_cs_n),
    .rx_word    (spi_rx_word),
    .rx_done    (spi_rx_done),
    .busy       (spi_busy)
  );

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_SSI_NEEDS_PIN: assert property ($rose(ssi_en_reg) |-> $past(sen_low_seen_reg))
    else $error("ssi mode entered with enable pin high");
  AST_SSI_NEEDS_NVM: assert property (ssi_en_reg |-> nvm_ok_reg)
    else $error("ssi mode without valid memory");
  AST_ERR_LOW_INIT: assert property (!init_done_reg |-> !error_out_n)
    else $error("error output high during init");
  AST_ERR_RISE: assert property (init_last |=> error_out_n && init_done_reg)
    else $error("error output not released after init");
  AST_SSI_IDLE_HIGH: assert property (!ssi_en_reg |=> ssi_data_out)
    else $error("ssi data not idle while disabled");
  AST_SPI_OFF: assert property (!spi_en ##1 !spi_en |-> spi_cs_n && !spi_sclk)
    else $error("spi active while disabled");
  AST_SPI_CLK_IDLE: assert property (spi_cs_n |-> !spi_sclk)
    else $error("spi clock not idle low");
  AST_SPI_HALF: assert property ($rose(spi_sclk) |=> $fell(spi_sclk))
    else $error("spi clock high longer than one cycle");
  AST_MOSI_ON_FALL: assert property ($changed(spi_mosi) && !spi_cs_n |-> !spi_sclk)
    else $error("mosi changed while clock high");
  AST_RX_IN_FRAME: assert property (spi_en && !short_frame |-> frame_word == spi_rx_reg)
    else $error("spi data missing from frame");

  COV_FRAME: cover property (frame_done);
  COV_SPI_WORD: cover property (spi_rx_done ##1 spi_rx_reg == spi_rx_word);
  COV_IRQ: cover property ($rose(irq));

endmodule
`default_nettype wire

// ===== core/pso_pkg.sv
package pso_pkg;

  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_IFACE_CFG  = 8'h00;
  localparam logic [7:0] ADDR_MAIN_CFG   = 8'h04;
  localparam logic [7:0] ADDR_POSITION   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
  localparam logic [7:0] ADDR_SPI_RX     = 8'h14;
  localparam logic [7:0] ADDR_STATE      = 8'h18;

  // Field positions of interface_config_reg
  localparam int TMO_LSB   = 0;
  localparam int TMO_W     = 16;
  localparam int RING_BIT  = 16;
  localparam int SHORT_BIT = 17;
  localparam int SEL_BIT   = 18;

  // Field positions of main_config_reg
  localparam int MODE_LSB     = 0;
  localparam int MODE_SPI_BIT = 3;

  // Interrupt status and state register bits
  localparam int IRQ_FRAME_BIT  = 0;
  localparam int IRQ_SPI_BIT    = 1;
  localparam int ST_SSI_BIT     = 0;
  localparam int ST_INIT_BIT    = 1;
  localparam int ST_NVM_BIT     = 2;
  localparam int ST_SPI_BSY_BIT = 3;

  // Values after reset: select, short frame and ring set, timeout field 0x40
  localparam logic [31:0] IFACE_CFG_RST = 32'h0007_0040;
  localparam logic [31:0] MAIN_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RST       = 2'h0;

  // Frame geometry
  localparam logic [5:0]  FRAME_LONG  = 6'h20;
  localparam logic [5:0]  FRAME_SHORT = 6'h14;
  localparam logic [11:0] SHORT_PAD   = 12'h000;
  localparam logic [16:0] TMO_EXTRA   = 17'h00003;

  // Timing: init time in ns, clock rate in MHz, count rounded up
  localparam int CLK_FREQ_MHZ = 200;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYC     = (INIT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [7:0] INIT_LAST = 8'(INIT_CYC - 1);

  // SPI master half-period schedule, clock at half the system rate
  localparam logic [6:0] SPI_HALVES     = 7'h40;
  localparam logic [6:0] SPI_FIRST_SMPL = 7'h03;
  localparam logic [6:0] SPI_LAST_HALF  = 7'h41;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SSI_IDLE, SSI_SHIFT, SSI_TMO} pso_ssi_state_e;
  typedef enum logic {SPI_IDLE, SPI_RUN} pso_spi_state_e;

endpackage

// ===== core/pso_ssi_tx.sv
`timescale 1ns/100ps
`default_nettype none
module pso_ssi_tx (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        enable,
  input  wire logic        ring_mode,
  input  wire logic        short_frame,
  input  wire logic [15:0] timeout_field,
  input  wire logic [31:0] frame_word,
  input  wire logic        sck_level,
  output logic             data_out,
  output logic             frame_done
);
  import pso_pkg::*;

  pso_ssi_state_e state_reg;
  logic           sck_prev_reg;
  logic [31:0]    shift_reg;
  logic [5:0]     bit_cnt_reg;
  logic [16:0]    tmo_cnt_reg;

  // Edge detect on the already synchronised clock level
  wire        sck_fall  = sck_prev_reg & ~sck_level;
  wire        sck_rise  = ~sck_prev_reg & sck_level;
  wire [5:0]  frame_len = short_frame ? FRAME_SHORT : FRAME_LONG;
  wire [16:0] tmo_limit = {1'b0, timeout_field} + TMO_EXTRA;
  wire        last_done = bit_cnt_reg == frame_len;

  // Frame shifter: latch on falling edge, one bit per rising edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= SSI_IDLE;
      sck_prev_reg <= 1'b1;
      shift_reg    <= WORD_ZERO;
      bit_cnt_reg  <= 6'h00;
      tmo_cnt_reg  <= 17'h00000;
      data_out     <= 1'b1;
      frame_done   <= 1'b0;
    end else begin
      sck_prev_reg <= sck_level;
      frame_done   <= 1'b0;
      if (!enable) begin
        state_reg <= SSI_IDLE;
        data_out  <= 1'b1;
      end else begin
        case (state_reg)
          SSI_IDLE: begin
            data_out <= 1'b1;
            if (sck_fall) begin
              shift_reg   <= frame_word;
              bit_cnt_reg <= 6'h00;
              tmo_cnt_reg <= 17'h00000;
              state_reg   <= SSI_SHIFT;
            end
          end
          SSI_SHIFT: begin
            // Clock high time; outside ring mode a frame the master cuts short ends at the timeout
            tmo_cnt_reg <= sck_level ? tmo_cnt_reg + 17'h00001 : 17'h00000;
            if (sck_rise && last_done) begin
              frame_done <= 1'b1;
              if (ring_mode) begin
                data_out    <= frame_word[31];
                shift_reg   <= {frame_word[30:0], 1'b0};
                bit_cnt_reg <= 6'h01;
              end else begin
                data_out    <= 1'b1;
                tmo_cnt_reg <= 17'h00000;
                state_reg   <= SSI_TMO;
              end
            end else if (sck_rise) begin
              data_out    <= shift_reg[31];
              shift_reg   <= {shift_reg[30:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end else if (!ring_mode && sck_level && tmo_cnt_reg >= tmo_limit) begin
              data_out  <= 1'b1;
              state_reg <= SSI_IDLE;
            end
          end
          SSI_TMO: begin
            // Any low clock restarts the wait, so a busy master never gets stale data
            data_out    <= 1'b1;
            tmo_cnt_reg <= sck_level ? tmo_cnt_reg + 17'h00001 : 17'h00000;
            if (tmo_cnt_reg >= tmo_limit) begin
              state_reg <= SSI_IDLE;
            end
          end
          default: state_reg <= SSI_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/pso_spi_master.sv
`timescale 1ns/100ps
`default_nettype none
module pso_spi_master (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        enable,
  input  wire logic [31:0] tx_word,
  input  wire logic        miso_level,
  output logic             spi_sclk,
  output logic             spi_mosi,
  output logic             spi_cs_n,
  output logic [31:0]      rx_word,
  output logic             rx_done,
  output logic             busy
);
  import pso_pkg::*;

  pso_spi_state_e state_reg;
  logic [6:0]     half_reg;
  logic [31:0]    tx_sh_reg;
  logic [31:0]    rx_sh_reg;

  // Schedule decode; sampling lags two cycles to cover the miso synchroniser
  wire [6:0]  half_nx  = half_reg + 7'h01;
  wire        fall_nx  = ~half_nx[0] & (half_nx < SPI_HALVES);
  wire        sample   = half_reg[0] & (half_reg >= SPI_FIRST_SMPL);
  wire [31:0] rx_shift = {rx_sh_reg[30:0], miso_level};
  assign busy = state_reg == SPI_RUN;

  // Cyclic 32-bit mode 0 transfer at half the system clock
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SPI_IDLE;
      half_reg  <= 7'h00;
      tx_sh_reg <= WORD_ZERO;
      rx_sh_reg <= WORD_ZERO;
      rx_word   <= WORD_ZERO;
      rx_done   <= 1'b0;
      spi_sclk  <= 1'b0;
      spi_mosi  <= 1'b0;
      spi_cs_n  <= 1'b1;
    end else begin
      rx_done <= 1'b0;
      case (state_reg)
        SPI_IDLE: begin
          spi_sclk <= 1'b0;
          spi_cs_n <= 1'b1;
          if (enable) begin
            tx_sh_reg <= tx_word;
            spi_mosi  <= tx_word[31];
            spi_cs_n  <= 1'b0;
            half_reg  <= 7'h00;
            state_reg <= SPI_RUN;
          end
        end
        SPI_RUN: begin
          if (!enable) begin
            state_reg <= SPI_IDLE;
            spi_sclk  <= 1'b0;
            spi_cs_n  <= 1'b1;
          end else begin
            half_reg <= half_nx;
            spi_sclk <= half_nx[0] & (half_nx < SPI_HALVES);
            if (fall_nx) begin
              tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
              spi_mosi  <= tx_sh_reg[30];
            end
            if (sample) begin
              rx_sh_reg <= rx_shift;
            end
            if (half_reg == SPI_LAST_HALF) begin
              rx_word   <= rx_shift;
              rx_done   <= 1'b1;
              spi_cs_n  <= 1'b1;
              state_reg <= SPI_IDLE;
            end
          end
        end
        default: state_reg <= SPI_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== testbench/pso_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none
// Mode 0 slave in place of the attached microcontroller
module pso_spi_slave (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic [31:0] tx_word,
  output logic             miso,
  output logic [31:0]      got,
  output int               done_cnt
);
  logic [31:0] out_sh;
  logic [31:0] in_sh;
  initial begin
    miso = 1'h0;
    done_cnt = 0;
  end
  // First bit must stand before the first rising edge
  always @(negedge cs_n) begin
    out_sh = tx_word;
    miso = tx_word[31];
  end
  // Sample on rise, shift on fall, MSB first
  always @(posedge sclk) if (!cs_n) in_sh = {in_sh[30:0], mosi};
  always @(negedge sclk) if (!cs_n) begin
    out_sh = {out_sh[30:0], 1'h0};
    miso = out_sh[31];
  end
  // Released line flips, so a stale bit never looks valid
  always @(posedge cs_n) begin
    got = in_sh;
    done_cnt = done_cnt + 1;
    miso = ~miso;
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pso_pkg::*;
  logic        clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, serial_enable_pin, ssi_clk_in, pos_error, pos_warning, irq;
  logic        nvm_config_valid, spi_miso, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, ssi_data_out, error_out_n, spi_sclk;
  logic        spi_mosi, spi_cs_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, position_in, nvm_interface_cfg, slv_tx, slv_got, rd;
  logic [63:0] sh;
  logic [19:0] e20;
  int          fails, checked, cyc, slv_cnt, c0;
  integer      seed;

  pso_top i_pso_top (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_enable_pin, .ssi_clk_in,
    .ssi_data_out, .error_out_n, .position_in, .pos_error, .pos_warning,
    .nvm_interface_cfg, .nvm_config_valid, .spi_sclk, .spi_mosi, .spi_miso, .spi_cs_n, .irq);
  pso_spi_slave i_pso_spi_slave (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .tx_word(slv_tx), .miso(spi_miso), .got(slv_got), .done_cnt(slv_cnt));

  initial clk_sys = 1'h0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic report_and_stop();
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Run is under two thousand cycles, so this only trips on a hang
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Readies are read before the edge's updates land
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Link clock off the system grid; data read just before each fall
  task automatic ssi_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      ssi_clk_in <= 1'h0;
      #32;
      ssi_clk_in <= 1'h1;
      #32;
      sh = {sh[62:0], ssi_data_out};
    end
  endtask

  function automatic logic [19:0] exp20(input logic [31:0] p, input logic e, input logic w);
    return {p[17:0], e, w};
  endfunction

  initial begin
    seed = 32'h2161;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {nrst, serial_enable_pin, pos_error, pos_warning} = 4'h0;
    ssi_clk_in = 1'h1;
    nvm_interface_cfg = 32'h0006_0004; // Select and short frame, timeout 4
    nvm_config_valid = 1'h1;
    position_in = $random(seed);
    slv_tx = $random(seed);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'h1;
    repeat (100) @(posedge clk_sys);
    chk("error_out_n init", 32'h0, 32'(error_out_n));
    repeat (110) @(posedge clk_sys);
    chk("error_out_n run", 32'h1, 32'(error_out_n));
    axi_rd(ADDR_IFACE_CFG);
    chk("iface cfg", nvm_interface_cfg, rd);
    axi_rd(ADDR_STATE);
    chk("state", 32'h7, rd);
    axi_rd(8'h40);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rr));
    axi_wr(8'h40, WORD_ZERO);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rr));
    {pos_error, pos_warning} <= 2'($random(seed));
    @(posedge clk_sys);
    ssi_pulses(21);
    e20 = exp20(position_in, pos_error, pos_warning);
    chk("short frame", 32'(e20), 32'(sh[20:1]));
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      chk("data in timeout", 32'h1, 32'(ssi_data_out));
    end
    // Cut frame: clock stops after five bits, the next frame must start afresh
    ssi_pulses(5);
    repeat (20) @(posedge clk_sys);
    ssi_pulses(21);
    chk("frame after cut", 32'(e20), 32'(sh[20:1]));
    axi_rd(ADDR_IRQ_STATUS);
    chk("status", 32'h1, rd);
    chk("irq masked", 32'h0, 32'(irq));
    axi_wr(ADDR_IRQ_MASK, 32'h1);
    chk("mask bresp", 32'(RESP_OKAY), 32'(rr));
    chk("irq on", 32'h1, 32'(irq));
    axi_wr(ADDR_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    axi_wr(ADDR_MAIN_CFG, 32'h8);
    c0 = slv_cnt;
    while (slv_cnt < c0 + 2) @(posedge clk_sys);
    chk("spi sent word", position_in, slv_got);
    axi_rd(ADDR_SPI_RX);
    chk("spi rx word", slv_tx, rd);
    axi_wr(ADDR_IFACE_CFG, 32'h0005_0004);
    ssi_pulses(64);
    chk("ring word 1", slv_tx, sh[63:32]);
    chk("ring word 2", slv_tx, sh[31:0]);
    report_and_stop();
  end
endmodule
`default_nettype wire
